// File: flash_checker.sv
// pin-level assertions for the host to flash device link
// assumes link_clk from the host end and the device reset as disable
`timescale 1ns/100ps
module flash_checker
   import flash_pkg::*;
(
   input wire logic link_clk,
   input wire logic nrst,
   input wire logic address_valid_n,
   input wire logic chip_enable_n,
   input wire logic write_strobe_n,
   input wire logic output_drive_n,
   input wire logic reset_n,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] host_data,
   input wire logic dev_data_oe,
   input wire logic ready
);
   // one domain; pins are sampled on the link clock like the device does
   default clocking cb @(posedge link_clk); endclocking
   default disable iff (!nrst);
   // repeat counts leave room for the device's synchroniser and filter
   a_oe_floats: assert property (output_drive_n [*6] |-> !dev_data_oe)
      else $error("data driven with output enable high");
   a_standby_floats: assert property (chip_enable_n [*6] |-> !dev_data_oe)
      else $error("data driven while deselected");
   a_reset_floats: assert property (!reset_n [*8] |-> ##2 (!dev_data_oe && !ready))
      else $error("outputs active during pin reset");
   a_reset_recovers: assert property ($rose(reset_n) |-> ##[1:200] ready)
      else $error("not ready after pin reset");
   a_strobe_qualified: assert property (!write_strobe_n |-> output_drive_n && !chip_enable_n)
      else $error("write strobe without enable");
   a_read_no_strobe: assert property (!output_drive_n |-> write_strobe_n)
      else $error("read and write strobes together");
   a_addr_phase: assert property (!address_valid_n |-> !chip_enable_n && write_strobe_n)
      else $error("address phase malformed");
   a_data_hold: assert property (!write_strobe_n && !$past(write_strobe_n)
      |-> $stable(host_data) && $stable(addr))
      else $error("write data moved under strobe");
   // main scenarios reached
   c_write: cover property (!write_strobe_n);
   c_read: cover property ($rose(dev_data_oe));
   c_reset: cover property ($rose(reset_n));
endmodule : flash_checker

// File: flash_dev.sv
// flash device end: write qualification, command decode, protection, reset, sleep
// assumes link_clk runs free from the host; array storage sits on the user side
`timescale 1ns/100ps
module flash_dev
   import flash_pkg::*;
#(
   parameter bit TOP_BOOT = 1'b0,
   parameter logic [DATA_W-1:0] MAKER_ID = 16'h00c3, // arbitrary value
   parameter logic [DATA_W-1:0] DEVICE_ID = 16'h003c // arbitrary value
) (
   input wire logic link_clk,
   input wire logic nrst,
   flash_if.dev bus,
   output logic [ADDR_W-1:0] arr_addr,
   input wire logic [DATA_W-1:0] arr_rdata,
   output logic op_start,
   output logic op_erase,
   output logic [ADDR_W-1:0] op_addr,
   output logic [DATA_W-1:0] op_data,
   output logic fast_mode,
   output logic sleep
);
   typedef enum logic [11:0] {
      CS_READ = 12'h001, CS_UL1 = 12'h002, CS_UL2 = 12'h004, CS_PROG = 12'h008,
      CS_E1 = 12'h010, CS_E2 = 12'h020, CS_E3 = 12'h040, CS_EWIN = 12'h080,
      CS_LOCK = 12'h100, CS_AUTO = 12'h200, CS_BUSY = 12'h400, CS_BXIT = 12'h800
   } cs_e;
   typedef struct packed {
      logic [PIN_N-1:0] p1, p2, p3, pf;
      logic [ADDR_W-1:0] a1, a2, wa, ra;
      logic [DATA_W-1:0] d1, d2;
      logic wr, pu_inh, bypass, sync, er, rst_act, rst_seen_busy;
      logic [DATA_W-1:0] cfg;
      cs_e st;
      logic [N_SECT-1:0] lock, sel;
      logic [7:0] sidx;
      logic [CW-1:0] cnt, rp, rdy, rh, stab;
      logic slp, doe, rdy_o, st_o, er_o, fast_o;
      logic [DATA_W-1:0] dout, od;
      logic [ADDR_W-1:0] oa;
   } dev_s;
   dev_s r_q, r_d;

   // block index: 8K boot blocks at both ends, 32K blocks between
   function automatic logic [7:0] sect_of(input logic [ADDR_W-1:0] a);
      if (a[21:15] == 7'h00) begin
         return {6'h00, a[14:13]};
      end else if (a[21:15] == TOP_BLK) begin
         return 8'd130 + {6'h00, a[14:13]};
      end
      return 8'd3 + {1'b0, a[21:15]};
   endfunction : sect_of

   function automatic logic prot(input dev_s r, input logic [7:0] s);
      logic wps;
      wps = TOP_BOOT ? (s == 8'd132 || s == 8'd133) : (s == 8'd0 || s == 8'd1);
      return r.lock[s]
         | (accel_e'(r.pf[P_ACC+:2]) == ACC_LOW)
         | (!r.pf[P_WP] && wps);
   endfunction : prot

   always_comb begin
      logic ce, we, oe, avd, wr_now, wr_end, acc_hv;
      logic [7:0] dat, s;
      r_d = r_q;
      // two flops on every pin, then a third flop for the pulse filter
      r_d.p1 = {bus.accel_program_input, bus.write_protect_n, bus.supply_low_lockout,
         bus.reset_n, bus.address_valid_n, bus.output_drive_n, bus.write_strobe_n,
         bus.chip_enable_n};
      r_d.p2 = r_q.p1;
      r_d.p3 = r_q.p2;
      r_d.a1 = bus.addr;
      r_d.a2 = r_q.a1;
      r_d.d1 = bus.data_pins;
      r_d.d2 = r_q.d1;
      // a level counts only once seen on two link edges in a row
      r_d.pf = (~(r_q.p2 ^ r_q.p3) & r_q.p2) | ((r_q.p2 ^ r_q.p3) & r_q.pf);
      ce = r_q.pf[P_CE];
      we = r_q.pf[P_WE];
      oe = r_q.pf[P_OE];
      avd = r_q.pf[P_AVD];
      acc_hv = accel_e'(r_q.pf[P_ACC+:2]) == ACC_HV;
      wr_now = !ce && !we && oe;
      wr_end = r_q.wr && !wr_now;
      r_d.wr = wr_now;
      dat = r_q.d2[7:0];
      s = sect_of(r_q.wa);
      r_d.st_o = 1'b0;
      // address latched while the address phase lasts or at write start
      if ((!avd && !ce) || (wr_now && !r_q.wr)) begin
         r_d.wa = r_q.a2;
      end
      if (we) begin
         r_d.pu_inh = 1'b0;
      end
      // command decode on the rising edge of the strobe
      if (wr_end && !r_q.pu_inh) begin
         if (dat == CMD_RESET && r_q.st != CS_BUSY) begin
            r_d.st = CS_READ;
         end else begin
            unique case (r_q.st)
               CS_READ, CS_AUTO: begin
                  if ((r_q.bypass || acc_hv) && dat == CMD_PROG) begin
                     r_d.st = CS_PROG;
                  end else if (r_q.bypass && dat == CMD_AUTO) begin
                     r_d.st = CS_BXIT;
                  end else if (dat == CMD_UL1 && r_q.wa[11:0] == UL_ADDR1) begin
                     r_d.st = CS_UL1;
                  end
               end
               CS_UL1: r_d.st = (dat == CMD_UL2 && r_q.wa[11:0] == UL_ADDR2) ? CS_UL2 : CS_READ;
               CS_UL2: begin
                  r_d.st = CS_READ;
                  unique case (dat)
                     CMD_PROG: r_d.st = CS_PROG;
                     CMD_ERASE: r_d.st = CS_E1;
                     CMD_LOCK: r_d.st = CS_LOCK;
                     CMD_BYPASS: r_d.bypass = 1'b1;
                     CMD_AUTO: r_d.st = r_q.sync ? CS_READ : CS_AUTO;
                     CMD_CFG: begin
                        r_d.cfg = r_q.wa[DATA_W-1:0];
                        r_d.sync = 1'b1;
                     end
                     default: r_d.st = CS_READ;
                  endcase
               end
               CS_PROG: begin
                  r_d.st = CS_READ;
                  if (!prot(r_q, s)) begin
                     r_d.st = CS_BUSY;
                     r_d.st_o = 1'b1;
                     r_d.er_o = 1'b0;
                     r_d.oa = r_q.wa;
                     r_d.od = r_q.d2;
                     r_d.cnt = PROG_CYC;
                     r_d.er = 1'b0;
                  end
               end
               CS_E1: r_d.st = (dat == CMD_UL1) ? CS_E2 : CS_READ;
               CS_E2: r_d.st = (dat == CMD_UL2) ? CS_E3 : CS_READ;
               CS_E3, CS_EWIN: begin
                  // further block commands inside the window add blocks
                  r_d.st = CS_READ;
                  if (dat == CMD_SECT) begin
                     r_d.sel[s] = 1'b1;
                     r_d.st = CS_EWIN;
                     r_d.cnt = EWIN_CYC;
                  end else if (dat == CMD_CHIP && r_q.st == CS_E3) begin
                     r_d.sel = '1;
                     r_d.st = CS_BUSY;
                     r_d.er = 1'b1;
                     r_d.sidx = 8'h00;
                     r_d.cnt = '0;
                  end
               end
               CS_LOCK: begin
                  r_d.lock[s] = r_q.d2[0];
                  r_d.st = CS_READ;
               end
               CS_BXIT: begin
                  if (dat == CMD_EXIT) begin
                     r_d.bypass = 1'b0;
                  end
                  r_d.st = CS_READ;
               end
               CS_BUSY: r_d.st = CS_BUSY;
            endcase
         end
      end
      // erase window timeout, then block-by-block sweep skipping locked ones
      if (r_q.st == CS_EWIN && !wr_end) begin
         if (r_q.cnt == '0) begin
            r_d.st = CS_BUSY;
            r_d.er = 1'b1;
            r_d.sidx = 8'h00;
         end else begin
            r_d.cnt = r_q.cnt - 1'b1;
         end
      end
      if (r_q.st == CS_BUSY) begin
         if (r_q.cnt != '0) begin
            r_d.cnt = r_q.cnt - 1'b1;
         end else if (!r_q.er || r_q.sidx > LAST_SECT) begin
            r_d.st = CS_READ;
            r_d.sel = '0;
         end else begin
            if (r_q.sel[r_q.sidx] && !prot(r_q, r_q.sidx)) begin
               r_d.st_o = 1'b1;
               r_d.er_o = 1'b1;
               r_d.oa = {14'h0000, r_q.sidx};
               r_d.cnt = ERASE_CYC;
            end
            r_d.sidx = r_q.sidx + 8'h01;
         end
      end
      // accel level acts as bypass only while applied, so removing it ends fast mode
      r_d.fast_o = r_q.bypass || acc_hv;
      // supply lockout: no writes, nothing running, back to array read
      if (r_q.pf[P_LKO]) begin
         r_d.st = CS_READ;
         r_d.st_o = 1'b0;
         r_d.sel = '0;
         r_d.cnt = '0;
         r_d.bypass = 1'b0;
         r_d.pu_inh = 1'b1;
      end
      // hardware reset: counted low time, then abort and recover
      if (!r_q.pf[P_RST]) begin
         r_d.rp = (r_q.rp == RP_CYC) ? r_q.rp : r_q.rp + 1'b1;
         if (r_q.rp == RP_CYC) begin
            if (!r_q.rst_act) begin
               r_d.rst_seen_busy = r_q.st == CS_BUSY;
            end
            r_d.rst_act = 1'b1;
            r_d.st = CS_READ;
            r_d.st_o = 1'b0;
            r_d.cfg = '0;
            r_d.sync = 1'b0;
            r_d.bypass = 1'b0;
            r_d.sel = '0;
            r_d.cnt = '0;
            r_d.wr = 1'b0;
         end
      end else begin
         r_d.rp = '0;
         if (r_q.rst_act) begin
            r_d.rst_act = 1'b0;
            r_d.rdy = r_q.rst_seen_busy ? RDY_EA_CYC : RDY_CYC;
            r_d.rh = RH_CYC;
         end else begin
            r_d.rdy = (r_q.rdy == '0) ? r_q.rdy : r_q.rdy - 1'b1;
            r_d.rh = (r_q.rh == '0) ? r_q.rh : r_q.rh - 1'b1;
         end
      end
      r_d.rdy_o = !r_d.rst_act && r_d.rdy == '0 && r_d.st != CS_BUSY;
      // stable address counts toward sleep; data latched while asleep
      if (r_q.a2 != r_q.ra) begin
         r_d.ra = r_q.a2;
         r_d.stab = '0;
         r_d.slp = r_q.sync && r_q.slp;
      end else if (r_q.stab < (r_q.sync ? ACC_CYC : SLEEP_CYC)) begin
         r_d.stab = r_q.stab + 1'b1;
      end else begin
         r_d.slp = 1'b1;
      end
      // reset refreshes the latch, else a sleeping read keeps stale id codes
      if (!r_q.slp || r_q.rst_act || (!r_q.sync && r_q.a2 != r_q.ra)) begin
         if (r_q.st == CS_AUTO) begin
            unique case (r_q.ra[1:0])
               2'h0: r_d.dout = MAKER_ID;
               2'h1: r_d.dout = DEVICE_ID;
               2'h2: r_d.dout = {15'h0000, prot(r_q, sect_of(r_q.ra))};
               default: r_d.dout = '0;
            endcase
         end else begin
            r_d.dout = arr_rdata;
         end
      end
      // drive only when selected, reading and out of reset
      r_d.doe = !ce && !oe && !r_d.rst_act && r_q.rh == '0;
   end

   // one register for all state
   always_ff @(posedge link_clk) begin
      if (!nrst) begin
         r_q <= '0;
         r_q.p1 <= '1;
         r_q.p2 <= '1;
         r_q.p3 <= '1;
         r_q.pf <= '1;
         r_q.pf[P_WE] <= 1'b0; // strobe counts low until seen high
         r_q.pu_inh <= 1'b1;
         r_q.st <= CS_READ;
      end else begin
         r_q <= r_d;
      end
   end

   assign bus.dev_data = r_q.dout;
   assign bus.dev_data_oe = r_q.doe;
   assign bus.ready = r_q.rdy_o;
   assign arr_addr = r_q.ra;
   assign op_start = r_q.st_o;
   assign op_erase = r_q.er_o;
   assign op_addr = r_q.oa;
   assign op_data = r_q.od;
   assign fast_mode = r_q.fast_o;
   assign sleep = r_q.slp;
endmodule : flash_dev

// File: flash_host.sv
// host end: link clock divider and timed write and read cycles on the pins
// assumes a user issues one command at a time through the cmd port
`timescale 1ns/100ps
module flash_host
   import flash_pkg::*;
#(
   parameter int DIV = LINK_DIV
) (
   input wire logic clk,
   input wire logic nrst,
   flash_if.host bus,
   input wire logic cmd_valid,
   input wire logic cmd_write,
   input wire logic [ADDR_W-1:0] cmd_addr,
   input wire logic [DATA_W-1:0] cmd_wdata,
   input wire logic flash_reset_n,
   input wire logic wp_n,
   input wire logic [1:0] accel,
   input wire logic lockout,
   output logic cmd_ready,
   output logic rsp_valid,
   output logic [DATA_W-1:0] rsp_rdata,
   output logic dev_ready
);
   // a slow link clock would let a phase end before the device has answered
   if (DIV < 1 || DIV > 255 || 16 * DIV > int'(PHASE_CYC)) begin : g_div_chk
      $error("DIV too large for the phase time");
   end
   typedef enum logic [4:0] {
      H_IDLE = 5'h01, H_ADDR = 5'h02, H_DATA = 5'h04, H_REC = 5'h08, H_READ = 5'h10
   } hst_e;
   typedef struct packed {
      hst_e st;
      logic [7:0] div, ph;
      logic lclk, avd_n, ce_n, we_n, oe_n, doe, rdy, rv, rst_n, wp, lko;
      logic [1:0] acc;
      logic [ADDR_W-1:0] a;
      logic [DATA_W-1:0] d, d1, d2, rd;
      logic r1, r2;
   } hst_s;
   hst_s r_q, r_d;

   always_comb begin
      r_d = r_q;
      // link clock from a divider of clk
      if (r_q.div == 8'(DIV - 1)) begin
         r_d.div = 8'h00;
         r_d.lclk = !r_q.lclk;
      end else begin
         r_d.div = r_q.div + 8'h01;
      end
      r_d.d1 = bus.data_pins;
      r_d.d2 = r_q.d1;
      r_d.r1 = bus.ready;
      r_d.r2 = r_q.r1;
      r_d.rdy = r_q.r2;
      r_d.rst_n = flash_reset_n;
      r_d.wp = wp_n;
      r_d.acc = accel;
      r_d.lko = lockout;
      r_d.rv = 1'b0;
      r_d.ph = (r_q.ph == 8'h00) ? r_q.ph : r_q.ph - 8'h01;
      unique case (r_q.st)
         H_IDLE: begin
            if (cmd_valid) begin
               r_d.a = cmd_addr;
               r_d.d = cmd_wdata;
               r_d.ph = PHASE_CYC;
               r_d.ce_n = 1'b0;
               r_d.avd_n = 1'b0;
               r_d.st = cmd_write ? H_ADDR : H_READ;
               r_d.oe_n = cmd_write;
            end
         end
         H_ADDR: begin
            if (r_q.ph == 8'h00) begin
               r_d.avd_n = 1'b1;
               r_d.we_n = 1'b0;
               r_d.doe = 1'b1;
               r_d.ph = PHASE_CYC;
               r_d.st = H_DATA;
            end
         end
         H_DATA: begin
            if (r_q.ph == 8'h00) begin
               r_d.we_n = 1'b1;
               r_d.ph = PHASE_CYC;
               r_d.st = H_REC;
            end
         end
         H_REC: begin
            // enable stays low and data held past the strobe rise
            if (r_q.ph == 8'h00) begin
               r_d.ce_n = 1'b1;
               r_d.doe = 1'b0;
               r_d.rv = 1'b1;
               r_d.st = H_IDLE;
            end
         end
         H_READ: begin
            if (r_q.ph == 8'h00) begin
               r_d.avd_n = 1'b1;
               r_d.ce_n = 1'b1;
               r_d.oe_n = 1'b1;
               r_d.rd = r_q.d2;
               r_d.rv = 1'b1;
               r_d.st = H_IDLE;
            end
         end
      endcase
   end

   // one register for all state
   always_ff @(posedge clk) begin
      if (!nrst) begin
         r_q <= '0;
         r_q.st <= H_IDLE;
         r_q.avd_n <= 1'b1;
         r_q.ce_n <= 1'b1;
         r_q.we_n <= 1'b1;
         r_q.oe_n <= 1'b1;
         r_q.wp <= 1'b1;
         r_q.acc <= 2'h1;
         r_q.d1 <= '1;
         r_q.d2 <= '1;
      end else begin
         r_q <= r_d;
      end
   end

   assign bus.link_clk = r_q.lclk;
   assign bus.address_valid_n = r_q.avd_n;
   assign bus.chip_enable_n = r_q.ce_n;
   assign bus.write_strobe_n = r_q.we_n;
   assign bus.output_drive_n = r_q.oe_n;
   assign bus.reset_n = r_q.rst_n;
   assign bus.write_protect_n = r_q.wp;
   assign bus.accel_program_input = r_q.acc;
   assign bus.supply_low_lockout = r_q.lko;
   assign bus.addr = r_q.a;
   assign bus.host_data = r_q.d;
   assign bus.host_data_oe = r_q.doe;
   assign cmd_ready = r_q.st == H_IDLE;
   assign rsp_valid = r_q.rv;
   assign rsp_rdata = r_q.rd;
   assign dev_ready = r_q.rdy;
endmodule : flash_host

// File: flash_if.sv
// the pins between host and flash device, one modport per end
// assumes each end drives only its own enable and data
`timescale 1ns/100ps
interface flash_if;
   import flash_pkg::*;
   logic link_clk;
   logic address_valid_n;
   logic chip_enable_n;
   logic write_strobe_n;
   logic output_drive_n;
   logic reset_n;
   logic write_protect_n;
   logic [1:0] accel_program_input;
   logic supply_low_lockout;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] host_data;
   logic host_data_oe;
   logic [DATA_W-1:0] dev_data;
   logic dev_data_oe;
   logic ready;
   logic [DATA_W-1:0] data_pins;
   // pulled-up shared bus
   assign data_pins = dev_data_oe ? dev_data : (host_data_oe ? host_data : '1);
   modport host (output link_clk, address_valid_n, chip_enable_n, write_strobe_n,
      output_drive_n, reset_n, write_protect_n, accel_program_input,
      supply_low_lockout, addr, host_data, host_data_oe,
      input data_pins, ready);
   modport dev (input link_clk, address_valid_n, chip_enable_n, write_strobe_n,
      output_drive_n, reset_n, write_protect_n, accel_program_input,
      supply_low_lockout, addr, data_pins,
      output dev_data, dev_data_oe, ready);
endinterface : flash_if

// File: flash_pkg.sv
// constants, encodings and timing counts shared by both ends of the flash link
// assumes the device end runs on the link clock and the host end on clk
package flash_pkg;
   localparam int ADDR_W = 22;
   localparam int DATA_W = 16;
   localparam int N_SECT = 134;
   localparam logic [7:0] LAST_SECT = 8'h85;
   localparam logic [6:0] TOP_BLK = 7'h7f;
   // pin positions inside the sampled control vector
   localparam int P_CE = 0;
   localparam int P_WE = 1;
   localparam int P_OE = 2;
   localparam int P_AVD = 3;
   localparam int P_RST = 4;
   localparam int P_LKO = 5;
   localparam int P_WP = 6;
   localparam int P_ACC = 7;
   localparam int PIN_N = 9;
   // command encodings
   localparam logic [11:0] UL_ADDR1 = 12'h555;
   localparam logic [11:0] UL_ADDR2 = 12'h2aa;
   localparam logic [7:0] CMD_UL1 = 8'haa;
   localparam logic [7:0] CMD_UL2 = 8'h55;
   localparam logic [7:0] CMD_PROG = 8'ha0;
   localparam logic [7:0] CMD_ERASE = 8'h80;
   localparam logic [7:0] CMD_SECT = 8'h30;
   localparam logic [7:0] CMD_CHIP = 8'h10;
   localparam logic [7:0] CMD_AUTO = 8'h90;
   localparam logic [7:0] CMD_BYPASS = 8'h20;
   localparam logic [7:0] CMD_LOCK = 8'h60;
   localparam logic [7:0] CMD_CFG = 8'hc0;
   localparam logic [7:0] CMD_RESET = 8'hf0;
   localparam logic [7:0] CMD_EXIT = 8'h00;
   // accelerate pin levels
   typedef enum logic [1:0] {ACC_LOW = 2'h0, ACC_HIGH = 2'h1, ACC_HV = 2'h2} accel_e;
   // device timing, link clock cycles
   localparam int LINK_NS = 160;
   localparam int T_RP_NS = 500;
   localparam int T_RH_NS = 200;
   localparam int T_READY_NS = 500;
   localparam int T_READY_EA_NS = 20000;
   localparam int ADDR_ACCESS_TIME_NS = 80;
   localparam int T_SLEEP_NS = 60;
   localparam int CW = 8;
   localparam logic [CW-1:0] RP_CYC = CW'((T_RP_NS + LINK_NS - 1) / LINK_NS);
   localparam logic [CW-1:0] RH_CYC = CW'((T_RH_NS + LINK_NS - 1) / LINK_NS);
   localparam logic [CW-1:0] RDY_CYC = CW'(T_READY_NS / LINK_NS);
   localparam logic [CW-1:0] RDY_EA_CYC = CW'(T_READY_EA_NS / LINK_NS);
   localparam logic [CW-1:0] ACC_CYC = CW'((ADDR_ACCESS_TIME_NS + LINK_NS - 1) / LINK_NS);
   localparam logic [CW-1:0] SLEEP_CYC =
      CW'((ADDR_ACCESS_TIME_NS + T_SLEEP_NS + LINK_NS - 1) / LINK_NS);
   localparam logic [CW-1:0] PROG_CYC = 8'h08;
   localparam logic [CW-1:0] ERASE_CYC = 8'h20;
   localparam logic [CW-1:0] EWIN_CYC = 8'h10;
   // host timing, clk cycles
   localparam int LINK_DIV = 4;
   // long enough for the device's pin filter, output stage and our own sampling
   localparam logic [7:0] PHASE_CYC = 8'h40;
endpackage : flash_pkg

// File: testbench.sv
// self-checking bench: host and device ends joined by the pin interface
// assumes the host end divides clk to make the link clock
`timescale 1ns/100ps
module testbench;
   import flash_pkg::*;
   logic clk = 1'b0, nrst = 1'b0, dev_nrst = 1'b0, cmd_valid = 1'b0, cmd_write = 1'b0;
   logic flash_reset_n = 1'b1, wp_n = 1'b1, lockout = 1'b0;
   logic [1:0] accel = 2'h1;
   logic [ADDR_W-1:0] cmd_addr = '0, arr_addr, op_addr;
   logic [DATA_W-1:0] cmd_wdata = '0, rsp_rdata, op_data, rd_q;
   logic cmd_ready, rsp_valid, dev_ready, op_start, op_erase, fast_mode, asleep;
   int num_errors = 0, num_checks = 0, ops = 0, base;
   flash_if link ();
   flash_host flash_host_i (.clk(clk), .nrst(nrst), .bus(link), .cmd_valid(cmd_valid),
      .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .lockout(lockout),
      .flash_reset_n(flash_reset_n), .wp_n(wp_n), .accel(accel), .cmd_ready(cmd_ready),
      .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .dev_ready(dev_ready));
   // array stand-in: data is a fixed scramble of the address
   flash_dev #(.MAKER_ID(16'h1234), .DEVICE_ID(16'h4321)) flash_dev_i (.link_clk(link.link_clk),
      .nrst(dev_nrst), .bus(link), .arr_addr(arr_addr), .arr_rdata(arr_addr[15:0] ^ 16'ha5a5),
      .op_start(op_start), .op_erase(op_erase), .op_addr(op_addr), .op_data(op_data),
      .fast_mode(fast_mode), .sleep(asleep));
   flash_checker flash_checker_i (.link_clk(link.link_clk), .nrst(dev_nrst),
      .address_valid_n(link.address_valid_n), .chip_enable_n(link.chip_enable_n),
      .write_strobe_n(link.write_strobe_n), .output_drive_n(link.output_drive_n),
      .reset_n(link.reset_n), .addr(link.addr), .host_data(link.host_data),
      .dev_data_oe(link.dev_data_oe), .ready(link.ready));
   initial forever #10 clk = ~clk;
   // count array operations the device launches
   always @(posedge link.link_clk) if (op_start === 1'b1) ops++;
   task automatic conclude;
      if (num_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : conclude
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   function automatic logic flag(input int k);
      return k == 0 ? cmd_ready : (k == 1 ? rsp_valid : dev_ready);
   endfunction : flag
   // bounded wait at the falling edge, where outputs have settled
   task automatic hold(input int k, input int lim);
      int n;
      n = 0;
      while (flag(k) !== 1'b1) begin
         @(negedge clk);
         n++;
         if (n > lim) begin
            num_errors++;
            conclude();
         end
      end
   endtask : hold
   // one host command, sent once the host is ready with valid high for one clk, result kept in rd_q
   task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      hold(0, 400);
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_write <= w;
      cmd_addr <= a;
      cmd_wdata <= d;
      @(posedge clk);
      cmd_valid <= 1'b0;
      @(negedge clk);
      hold(1, 400);
      rd_q = rsp_rdata;
      @(negedge clk);
   endtask : xfer
   task automatic ul;
      xfer(1'b1, {10'h0, UL_ADDR1}, {8'h0, CMD_UL1});
      xfer(1'b1, {10'h0, UL_ADDR2}, {8'h0, CMD_UL2});
   endtask : ul
   task automatic seq(input logic [7:0] c);
      ul();
      xfer(1'b1, {10'h0, UL_ADDR1}, {8'h0, c});
   endtask : seq
   // long enough for an erase window to close, then wait for ready through the sweep
   task automatic settle;
      repeat (600) @(negedge clk);
      hold(2, 4000);
   endtask : settle
   task automatic prog(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input int n);
      base = ops;
      seq(CMD_PROG);
      xfer(1'b1, a, d);
      settle();
      chk("op count", n, ops - base);
      if (n > 0) begin
         chk("op addr", a, op_addr);
         chk("op data", d, op_data);
      end
   endtask : prog
   // device reset is released only once the link clock runs
   initial begin
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      repeat (24) @(posedge clk);
      dev_nrst <= 1'b1;
      settle();
      xfer(1'b0, 22'h001234, 16'h0);
      chk("array read", 16'h1234 ^ 16'ha5a5, rd_q);
      chk("sleep", 1, asleep);
      prog(22'h010000, 16'hbeef, 1);
      seq(CMD_LOCK);
      xfer(1'b1, 22'h010000, 16'h0001);
      settle();
      prog(22'h010000, 16'h1111, 0);
      seq(CMD_LOCK);
      xfer(1'b1, 22'h010000, 16'h0000);
      settle();
      prog(22'h010000, 16'h2222, 1);
      @(posedge clk) wp_n <= 1'b0;
      prog(22'h000100, 16'h3333, 0);
      @(posedge clk) wp_n <= 1'b1;
      prog(22'h000100, 16'h4444, 1);
      @(posedge clk) accel <= ACC_LOW;
      prog(22'h020000, 16'h5555, 0);
      @(posedge clk);
      accel <= ACC_HIGH;
      lockout <= 1'b1;
      prog(22'h020000, 16'h6666, 0);
      @(posedge clk);
      lockout <= 1'b0;
      accel <= ACC_HV;
      settle();
      chk("fast mode", 1, fast_mode);
      base = ops;
      xfer(1'b1, 22'h000000, {8'h0, CMD_PROG});
      xfer(1'b1, 22'h030000, 16'h7777);
      settle();
      chk("two write program", 1, ops - base);
      @(posedge clk) accel <= ACC_HIGH;
      settle();
      chk("fast mode", 0, fast_mode);
      base = ops;
      seq(CMD_ERASE);
      ul();
      xfer(1'b1, 22'h040000, {8'h0, CMD_SECT});
      settle();
      chk("erase count", 1, ops - base);
      chk("erase kind", 1, op_erase);
      seq(CMD_AUTO);
      xfer(1'b0, 22'h000000, 16'h0);
      chk("maker id", 16'h1234, rd_q);
      xfer(1'b0, 22'h000001, 16'h0);
      chk("device id", 16'h4321, rd_q);
      @(posedge clk) flash_reset_n <= 1'b0;
      repeat (200) @(negedge clk);
      chk("ready in reset", 0, dev_ready);
      @(posedge clk) flash_reset_n <= 1'b1;
      settle();
      xfer(1'b0, 22'h000001, 16'h0);
      chk("read after reset", 16'h0001 ^ 16'ha5a5, rd_q);
      prog(22'h010000, 16'h9999, 1);
      conclude();
   end
endmodule : testbench
